// ==== bus_target_model.sv ====
// Bus target model: takes every launch and retires the oldest one later.
// Assumes launches arrive as one-cycle bus_req pulses on core_clk.
`timescale 1ns/100ps
`default_nettype none
module bus_target_model (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       bus_req,
    input  wire logic       slow,
    input  wire logic       hold,
    output logic            bus_ready,
    output logic            bus_done,
    output logic      [4:0] pending
);
    logic [1:0] wait_cnt;

    // Retire one completion after a short or a longer wait, none on hold
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_ready <= 1'b0;
            bus_done  <= 1'b0;
            pending   <= 5'h00;
            wait_cnt  <= 2'h0;
        end else begin
            bus_ready <= 1'b1;
            bus_done  <= 1'b0;
            wait_cnt  <= wait_cnt + 2'h1;
            pending   <= pending + {4'h0, bus_req} - {4'h0, bus_done};
            if (pending > {4'h0, bus_done} && !hold && (!slow || wait_cnt == 2'h3)) begin
                bus_done <= 1'b1;
                wait_cnt <= 2'h0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== mem_attr_order.sv ====
// Memory attribute and ordering block: decodes fetch and data addresses,
// blocks execute-never fetches, orders device/strongly ordered traffic,
// buffers one device write, and sequences the three barriers.
// Assumes core-side requests and bus-side answers are on core_clk.
// Operation
// - Normal accesses may reorder and speculate
// - Device keeps order among Device/Strongly Ordered
// - Strongly Ordered keeps order with everything
// - Device writes bufferable, Strongly Ordered never
// - Block execute-never fetches; fault only when executed
// - Earlier device/SO access observed first
// - Other accesses may complete out of order
// - Code region Normal and executable
// - SRAM region Normal and executable
// - Peripheral region Device, execute-never
// - External RAM Normal and executable
// - External device Device, execute-never
// - Private bus Strongly Ordered, execute-never
// - Protection unit overrides default type and execute-never; reserved fault stays from default map
// - Fetch ahead and from branch targets
// - Memory barrier drains before next access
// - Sync barrier drains before next instruction
// - Instruction barrier refetches prefetched instructions
// - Priority change takes effect after sync barrier
// - Strongly Ordered ordered without memory barrier
// - Reserved space returns bus fault
`timescale 1ns/100ps
`default_nettype none
module mem_attr_order (
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    // Instruction fetch from core
    input  wire logic                          fetch_req,
    input  wire logic                   [31:0] fetch_addr,
    input  wire logic                          fetch_spec,
    input  wire logic                          exec_blocked_instr,
    // Data access from core
    input  wire logic                          data_req,
    input  wire logic                          data_we,
    input  wire logic                   [31:0] data_addr,
    input  wire logic                   [31:0] data_wdata,
    input  wire logic                    [1:0] barrier_op,
    input  wire logic                          prio_change,
    // Protection unit override
    input  wire logic                          prot_valid,
    input  wire mem_attr_pkg::mem_type_t       prot_type,
    input  wire logic                          prot_no_exec,
    // Memory bus side
    input  wire logic                          bus_ready,
    input  wire logic                          bus_done,
    // Outputs
    output logic                               fetch_grant,
    output logic                               fetch_block,
    output logic                               fetch_is_spec,
    output logic                               data_grant,
    output logic                               bus_req,
    output logic                               bus_we,
    output logic                        [31:0] bus_addr,
    output logic                        [31:0] bus_wdata,
    output logic                         [1:0] bus_type,
    output logic                               bus_fault,
    output logic                               exec_fault,
    output logic                               exec_stall,
    output logic                               prefetch_flush,
    output logic                               prio_apply
);
    mem_attr_pkg::mem_type_t f_type;
    mem_attr_pkg::mem_type_t d_type;
    logic f_no_exec;
    logic f_fault;
    // Data side needs no execute-never flag: data may reach any region but reserved space
    logic d_fault;

    // Fetch path decode
    region_decode u_fetch_dec (
        .addr          (fetch_addr),
        .prot_valid    (prot_valid),
        .prot_type     (prot_type),
        .prot_no_exec  (prot_no_exec),
        .mtype         (f_type),
        .execute_never (f_no_exec),
        .map_fault     (f_fault)
    );

    // Data path decode
    region_decode u_data_dec (
        .addr          (data_addr),
        .prot_valid    (prot_valid),
        .prot_type     (prot_type),
        .prot_no_exec  (prot_no_exec),
        .mtype         (d_type),
        .execute_never (),
        .map_fault     (d_fault)
    );

    // Registers
    mem_attr_pkg::bar_state_t state_reg, state_next;
    logic [mem_attr_pkg::OUTS_W-1:0] outs_reg, outs_next;
    logic       ordered_reg;        // Outstanding work includes Device/SO
    logic       strong_reg;         // Outstanding work includes Strongly Ordered
    logic       wbuf_valid_reg;     // Buffered Device write held
    logic [31:0] wbuf_addr_reg;
    logic [31:0] wbuf_data_reg;
    logic       prio_pend_reg;
    logic       fetch_grant_reg;
    logic       fetch_block_reg;
    logic       fetch_spec_reg;
    logic       data_grant_reg;
    logic       bus_req_reg;
    logic       bus_we_reg;
    logic [31:0] bus_addr_reg;
    logic [31:0] bus_wdata_reg;
    logic [1:0] bus_type_reg;
    logic       bus_fault_reg;
    logic       exec_fault_reg;
    logic       exec_stall_reg;
    logic       flush_reg;
    logic       prio_apply_reg;

    // Access classification
    wire d_is_normal  = (d_type == mem_attr_pkg::MT_NORMAL);
    wire d_is_strong  = (d_type == mem_attr_pkg::MT_STRONG) ||
                        (d_type == mem_attr_pkg::MT_RESERVED);
    wire d_is_device  = (d_type == mem_attr_pkg::MT_DEVICE);
    wire is_access    = data_req && (barrier_op == mem_attr_pkg::BAR_NONE);
    wire is_barrier   = data_req && (barrier_op != mem_attr_pkg::BAR_NONE);
    wire drained      = (outs_reg == mem_attr_pkg::OUTS_ZERO) && !wbuf_valid_reg;
    wire outs_full    = (outs_reg == mem_attr_pkg::OUTS_MAX);

    // Ordering hazards: Device waits for ordered traffic, SO waits for all
    // A held Device write counts as ordered traffic too
    wire dev_hazard    = d_is_device && (ordered_reg || wbuf_valid_reg) && !drained;
    wire strong_hazard = d_is_strong && !drained;
    // Normal access may pass other Normal traffic but not Strongly Ordered
    wire norm_hazard   = d_is_normal && strong_reg && !drained;
    wire hazard        = dev_hazard | strong_hazard | norm_hazard;
    // Device writes go to the buffer; SO writes go straight out
    wire to_wbuf       = is_access && data_we && d_is_device && !d_fault;
    wire running       = (state_reg == mem_attr_pkg::ST_RUN);
    wire wbuf_drain    = wbuf_valid_reg && bus_ready && !outs_full &&
                         !(is_access && !to_wbuf && running);
    wire can_issue     = running && is_access && !hazard && !outs_full && bus_ready &&
                         !d_fault && !(to_wbuf && wbuf_valid_reg);
    wire buf_take      = can_issue && to_wbuf && !wbuf_valid_reg;
    wire direct_issue  = can_issue && !to_wbuf;
    wire fault_now     = running && is_access && d_fault;
    wire launch        = direct_issue | wbuf_drain;
    wire retire        = bus_done && (outs_reg != mem_attr_pkg::OUTS_ZERO);

    // Fetch: prefetch and branch-target fetch allowed unless XN, reserved, or a barrier is in progress
    wire fetch_ok      = fetch_req && running && !f_no_exec && !f_fault;
    wire fetch_no_exec = fetch_req && (f_no_exec || f_fault);

    // Outstanding count
    always_comb begin
        outs_next = outs_reg;
        if (launch && !retire) begin
            outs_next = outs_reg + mem_attr_pkg::OUTS_ONE;
        end else if (!launch && retire) begin
            outs_next = outs_reg - mem_attr_pkg::OUTS_ONE;
        end
    end

    // Barrier sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mem_attr_pkg::ST_RUN: begin
                if (is_barrier) begin
                    state_next = (barrier_op == mem_attr_pkg::BAR_SYNC) ?
                                 mem_attr_pkg::ST_SYNC : mem_attr_pkg::ST_DRAIN;
                end
            end
            mem_attr_pkg::ST_DRAIN: begin
                if (drained) begin
                    state_next = (barrier_op == mem_attr_pkg::BAR_INSTR) ?
                                 mem_attr_pkg::ST_FLUSH : mem_attr_pkg::ST_RUN;
                end
            end
            mem_attr_pkg::ST_SYNC: begin
                if (drained) begin
                    state_next = mem_attr_pkg::ST_RUN;
                end
            end
            mem_attr_pkg::ST_FLUSH: begin
                state_next = mem_attr_pkg::ST_RUN;
            end
            default: begin
                state_next = mem_attr_pkg::ST_RUN;
            end
        endcase
    end

    wire sync_done = (state_reg == mem_attr_pkg::ST_SYNC) && drained;

    // Sequencer and counters
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= mem_attr_pkg::ST_RUN;
            outs_reg    <= mem_attr_pkg::OUTS_ZERO;
            ordered_reg <= 1'b0;
            strong_reg  <= 1'b0;
        end else begin
            state_reg   <= state_next;
            outs_reg    <= outs_next;
            ordered_reg <= (outs_next != mem_attr_pkg::OUTS_ZERO) &&
                           (ordered_reg | (direct_issue && !d_is_normal) | wbuf_drain);
            strong_reg  <= (outs_next != mem_attr_pkg::OUTS_ZERO) &&
                           (strong_reg | (direct_issue && d_is_strong));
        end
    end

    // Device write buffer (one entry)
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wbuf_valid_reg <= 1'b0;
            wbuf_addr_reg  <= 32'h0000_0000;
            wbuf_data_reg  <= 32'h0000_0000;
        end else begin
            if (buf_take) begin
                wbuf_valid_reg <= 1'b1;
                wbuf_addr_reg  <= data_addr;
                wbuf_data_reg  <= data_wdata;
            end else if (wbuf_drain) begin
                wbuf_valid_reg <= 1'b0;
            end
        end
    end

    // Priority change pending until sync barrier completes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prio_pend_reg  <= 1'b0;
            prio_apply_reg <= 1'b0;
        end else begin
            prio_pend_reg  <= prio_change | (prio_pend_reg & !sync_done);
            prio_apply_reg <= sync_done & (prio_pend_reg | prio_change);
        end
    end

    // Fetch outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_grant_reg <= 1'b0;
            fetch_block_reg <= 1'b0;
            fetch_spec_reg  <= 1'b0;
            exec_fault_reg  <= 1'b0;
            flush_reg       <= 1'b0;
            exec_stall_reg  <= 1'b0;
        end else begin
            fetch_grant_reg <= fetch_ok;
            fetch_block_reg <= fetch_no_exec;
            fetch_spec_reg  <= fetch_ok & fetch_spec;
            exec_fault_reg  <= exec_blocked_instr;
            flush_reg       <= (state_reg == mem_attr_pkg::ST_FLUSH);
            exec_stall_reg  <= (state_next == mem_attr_pkg::ST_SYNC);
        end
    end

    // Bus launch: direct access wins; buffered write drains only while no unbuffered access is presented in run
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_grant_reg <= 1'b0;
            bus_req_reg    <= 1'b0;
            bus_we_reg     <= 1'b0;
            bus_addr_reg   <= 32'h0000_0000;
            bus_wdata_reg  <= 32'h0000_0000;
            bus_type_reg   <= mem_attr_pkg::MT_NORMAL;
            bus_fault_reg  <= 1'b0;
        end else begin
            data_grant_reg <= can_issue;
            bus_req_reg    <= launch;
            bus_fault_reg  <= fault_now;
            if (direct_issue) begin
                bus_we_reg    <= data_we;
                bus_addr_reg  <= data_addr;
                bus_wdata_reg <= data_wdata;
                bus_type_reg  <= d_type;
            end else if (wbuf_drain) begin
                bus_we_reg    <= 1'b1;
                bus_addr_reg  <= wbuf_addr_reg;
                bus_wdata_reg <= wbuf_data_reg;
                bus_type_reg  <= mem_attr_pkg::MT_DEVICE;
            end
        end
    end

    assign fetch_grant    = fetch_grant_reg;
    assign fetch_block    = fetch_block_reg;
    assign fetch_is_spec  = fetch_spec_reg;
    assign data_grant     = data_grant_reg;
    assign bus_req        = bus_req_reg;
    assign bus_we         = bus_we_reg;
    assign bus_addr       = bus_addr_reg;
    assign bus_wdata      = bus_wdata_reg;
    assign bus_type       = bus_type_reg;
    assign bus_fault      = bus_fault_reg;
    assign exec_fault     = exec_fault_reg;
    assign exec_stall     = exec_stall_reg;
    assign prefetch_flush = flush_reg;
    assign prio_apply     = prio_apply_reg;
endmodule
`default_nettype wire

// ==== mem_attr_order_bench.sv ====
// Self-checking bench: fetch decode, data ordering, faults and barriers.
// Assumes the bus target model on the memory side of the block.
`timescale 1ns/100ps
`default_nettype none
module mem_attr_order_bench;
    logic                    core_clk = 1'b0;
    logic                    rst_n = 1'b0;
    logic                    fetch_req, fetch_spec, exec_blocked_instr, data_req, data_we;
    logic                    prio_change, prot_valid, prot_no_exec, slow, hold;
    logic             [31:0] fetch_addr, data_addr, data_wdata, bus_addr, bus_wdata;
    logic              [1:0] barrier_op, bus_type, f;
    mem_attr_pkg::mem_type_t prot_type;
    logic                    bus_ready, bus_done, fetch_grant, fetch_block, fetch_is_spec;
    logic                    data_grant, bus_req, bus_we, bus_fault, exec_fault;
    logic                    exec_stall, prefetch_flush, prio_apply;
    logic              [4:0] pending;
    logic             [67:0] e;
    logic             [67:0] dq[$];
    logic              [1:0] fq[$];
    int                      error_cnt = 0;
    int                      checks = 0;

    always #25 core_clk = ~core_clk;

    mem_attr_order i_mem_attr_order (.*);
    bus_target_model i_bus_target_model (.*);

    task automatic end_sim;
        if (error_cnt == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        error_cnt++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) fail(msg);
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Expected {fault, execute_never, type} of the default map
    function automatic logic [3:0] decode(input logic [31:0] a);
        if (a < mem_attr_pkg::SRAM_BASE) return 4'h0;
        if (a < mem_attr_pkg::PERIPH_BASE) return 4'h0;
        if (a < mem_attr_pkg::EXT_RAM_BASE) return 4'h5;
        if (a < mem_attr_pkg::EXT_DEV_BASE) return 4'h0;
        if (a < mem_attr_pkg::PPB_BASE) return 4'h5;
        if (a < mem_attr_pkg::RESERVED_BASE) return 4'h6;
        return 4'hE;
    endfunction

    // One cycle of fetch request; the caller lowers fetch_req after a run
    task automatic fetch(input logic [31:0] a, input logic sp);
        logic [3:0] d;
        d = decode(a);
        fq.push_back({(prot_valid ? prot_no_exec : d[2]) | d[3], sp});
        {fetch_req, fetch_addr, fetch_spec} = {1'b1, a, sp};
        tick(1);
    endtask

    // Data access held until granted or faulted; n counts the wait
    task automatic access(input logic we, input logic [31:0] a, output int n);
        logic [3:0] d;
        logic [31:0] w;
        d = prot_valid ? {1'b0, prot_no_exec, prot_type} : decode(a);
        w = $urandom;
        dq.push_back({d[3], d[1:0], we, w, a});
        {data_req, data_we, data_addr, data_wdata} = {1'b1, we, a, w};
        n = 0;
        do begin
            tick(1);
            n++;
        end while (!(data_grant === 1'b1 || bus_fault === 1'b1) && n < 60);
        if (n >= 60) begin
            fail("access never answered");
            end_sim;
        end
        data_req = 1'b0;
        tick(1);
    endtask

    // Barrier over held traffic; notes stall, flush and priority pulses
    task automatic barrier(input logic [1:0] op, output logic s, output logic fl,
                           output logic pa);
        logic z;
        {s, fl, pa, z} = 4'h0;
        {data_req, barrier_op} = {1'b1, op};
        tick(3);
        if (op == mem_attr_pkg::BAR_SYNC) check(exec_stall === 1'b1, "no stall");
        hold = 1'b0;
        for (int k = 0; k < 12; k++) begin
            tick(1);
            {s, fl, pa} = {s | exec_stall, fl | prefetch_flush, pa | prio_apply};
            // Hold the barrier one cycle past the drain so the sequencer sees it
            if (z && data_req) begin
                {data_req, barrier_op} = {1'b0, mem_attr_pkg::BAR_NONE};
            end
            z = pending === 5'h00;
        end
        if (data_req) begin
            fail("barrier never drained");
            end_sim;
        end
    endtask

    // Take the oldest note whenever a result shows and compare
    always @(negedge core_clk) begin
        if (bus_req === 1'b1 || bus_fault === 1'b1) begin
            if (dq.size() == 0) fail("bus result with no note");
            else begin
                e = dq.pop_front();
                check(e[67] === bus_fault && (e[67] || {bus_type, bus_we, bus_addr} ===
                      {e[66:64], e[31:0]} && (!e[64] || bus_wdata === e[63:32])),
                      "bus");
            end
        end
        if (fetch_grant === 1'b1 || fetch_block === 1'b1) begin
            if (fq.size() == 0) fail("fetch answer with no note");
            else begin
                f = fq.pop_front();
                check(fetch_block === f[1] && (f[1] || fetch_is_spec === f[0]), "fetch");
            end
        end
    end

    // Main sequence
    initial begin
        int n;
        logic s, fl, pa;
        logic [31:0] bnd [12];
        bnd = '{32'h1FFF_FFFC, 32'h2000_0000, 32'h3FFF_FFFC, 32'h4000_0000,
                32'h5FFF_FFFC, 32'h6000_0000, 32'h9FFF_FFFC, 32'hA000_0000,
                32'hDFFF_FFFC, 32'hE000_0000, 32'hE00F_FFFC, 32'hE010_0000};
        {fetch_req, fetch_spec, exec_blocked_instr, data_req, data_we} = 5'h00;
        {prio_change, prot_valid, prot_no_exec, slow, hold} = 5'h00;
        {fetch_addr, data_addr, data_wdata} = {3{32'h0000_0000}};
        barrier_op = mem_attr_pkg::BAR_NONE;
        prot_type = mem_attr_pkg::MT_NORMAL;
        void'($urandom(63));
        tick(4);
        rst_n = 1'b1;
        tick(1);
        slow = 1'b1;
        repeat (24) fetch($urandom, 1'($urandom));
        fetch_req = 1'b0;
        tick(2);
        check(exec_fault === 1'b0, "prefetch raised a fault");
        exec_blocked_instr = 1'b1;
        tick(1);
        exec_blocked_instr = 1'b0;
        check(exec_fault === 1'b1, "no fault on blocked execution");
        foreach (bnd[i]) access(1'(i), bnd[i], n);
        repeat (8) access(1'($urandom), $urandom, n);
        {prot_valid, prot_no_exec, prot_type} = {2'h3, mem_attr_pkg::MT_DEVICE};
        fetch(32'h0000_1000, 1'b0);
        fetch_req = 1'b0;
        access(1'b0, 32'h0000_2000, n);
        // Let earlier traffic retire before completions are held back
        {prot_valid, slow} = 2'h0;
        tick(16);
        hold = 1'b1;
        access(1'b0, 32'h4000_0100, n);
        access(1'b1, 32'h2000_0040, n);
        check(n == 1, "Normal access held behind Device");
        fork
            access(1'b0, 32'hA000_0000, n);
            begin tick(6); hold = 1'b0; end
        join
        check(n > 6, "Device passed an outstanding Device access");
        hold = 1'b1;
        access(1'b0, 32'h0000_0400, n);
        fork
            access(1'b1, 32'hE000_E010, n);
            begin tick(6); hold = 1'b0; end
        join
        check(n > 6, "Strongly ordered write went early");
        tick(8);
        for (int op = 1; op < 4; op++) begin
            hold = 1'b1;
            access(1'b0, 32'h2000_0080, n);
            prio_change = (op == 2);
            tick(1);
            prio_change = 1'b0;
            barrier(2'(op), s, fl, pa);
            check(s === (op == 2), "stall flag");
            check(fl === (op == 3), "prefetch flush");
            check(pa === (op == 2), "priority apply");
        end
        end_sim;
    end
endmodule
`default_nettype wire

// ==== mem_attr_order_sva.sv ====
// Checker on the ports of mem_attr_order: fetch decode, ordering, barriers.
// Assumes one clock, core_clk, and an asynchronous active low rst_n.
`timescale 1ns/100ps
`default_nettype none
module mem_attr_order_sva (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic        exec_blocked_instr,
    input wire logic        prot_valid,
    input wire logic        bus_done,
    input wire logic        fetch_grant,
    input wire logic        fetch_block,
    input wire logic        fetch_is_spec,
    input wire logic        bus_req,
    input wire logic  [1:0] bus_type,
    input wire logic        bus_fault,
    input wire logic        exec_fault,
    input wire logic        exec_stall,
    input wire logic        prio_apply
);
    logic [4:0] outs_cnt;

    // Fetch areas by the top address bits
    wire logic no_exec_area = fetch_addr[31:29] inside {3'h2, 3'h5, 3'h6, 3'h7};
    wire logic code_area    = fetch_addr[31:29] == 3'h0;

    // Launched minus retired transactions; a stray completion is ignored
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            outs_cnt <= 5'h00;
        end else begin
            outs_cnt <= outs_cnt + {4'h0, bus_req} - {4'h0, bus_done && outs_cnt != 5'h00};
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_exec_fault_copy: assert property (exec_blocked_instr |=> exec_fault)
        else $error("exec_fault did not follow the blocked execution");
    a_no_exec_fetch: assert property (
        fetch_req && !prot_valid && no_exec_area |=> !fetch_grant)
        else $error("fetch granted from execute-never space");
    a_code_fetch_open: assert property (
        fetch_req && !prot_valid && code_area |=> !fetch_block)
        else $error("fetch from code space was blocked");
    a_spec_is_granted: assert property (fetch_is_spec |-> fetch_grant)
        else $error("speculative flag without a grant");
    a_fault_no_launch: assert property (bus_fault |-> !bus_req)
        else $error("faulted access was launched");
    a_strong_alone: assert property (
        bus_req && bus_type == 2'h2 |-> outs_cnt == 5'h00)
        else $error("strongly ordered launch with traffic outstanding");
    a_sync_drained: assert property ($fell(exec_stall) |-> outs_cnt == 5'h00)
        else $error("stall ended with traffic outstanding");
    a_prio_after_sync: assert property (
        prio_apply |-> $past(exec_stall) || $past(exec_stall, 2))
        else $error("priority applied without a sync barrier");
endmodule

bind mem_attr_order mem_attr_order_sva i_mem_attr_order_sva (.*);
`default_nettype wire

// ==== mem_attr_pkg.sv ====
// Package for the memory attribute and ordering block.
// Assumes a 32-bit flat address space shared by fetch and data paths.
package mem_attr_pkg;

    // Memory types
    typedef enum logic [1:0] {
        MT_NORMAL   = 2'h0,
        MT_DEVICE   = 2'h1,
        MT_STRONG   = 2'h2,
        MT_RESERVED = 2'h3
    } mem_type_t;

    // Region boundaries (upper address bits compared)
    localparam logic [31:0] CODE_BASE     = 32'h0000_0000;
    localparam logic [31:0] SRAM_BASE     = 32'h2000_0000;
    localparam logic [31:0] PERIPH_BASE   = 32'h4000_0000;
    localparam logic [31:0] EXT_RAM_BASE  = 32'h6000_0000;
    localparam logic [31:0] EXT_DEV_BASE  = 32'hA000_0000;
    localparam logic [31:0] PPB_BASE      = 32'hE000_0000;
    localparam logic [31:0] RESERVED_BASE = 32'hE010_0000;

    // Data access kinds
    localparam logic [1:0] BAR_NONE = 2'h0;
    localparam logic [1:0] BAR_MEM   = 2'h1;
    localparam logic [1:0] BAR_SYNC  = 2'h2;
    localparam logic [1:0] BAR_INSTR = 2'h3;

    // Outstanding transaction counter width
    localparam int          OUTS_W    = 4;
    localparam logic [3:0]  OUTS_ZERO = 4'h0;
    localparam logic [3:0]  OUTS_ONE  = 4'h1;
    localparam logic [3:0]  OUTS_MAX  = 4'hF;

    // Barrier sequencer states
    typedef enum logic [3:0] {
        ST_RUN   = 4'h1,
        ST_DRAIN = 4'h2,
        ST_SYNC  = 4'h4,
        ST_FLUSH = 4'h8
    } bar_state_t;

endpackage

// ==== region_decode.sv ====
// Default address map decoder: memory type, execute-never and fault.
// Assumes the protection unit override arrives on the same clock.
`timescale 1ns/100ps
`default_nettype none
module region_decode (
    input  wire logic                   [31:0] addr,
    input  wire logic                          prot_valid,
    input  wire mem_attr_pkg::mem_type_t       prot_type,
    input  wire logic                          prot_no_exec,
    output mem_attr_pkg::mem_type_t            mtype,
    output logic                               execute_never,
    output logic                               map_fault
);
    // Range compares against region bases
    wire in_code   = addr <  mem_attr_pkg::SRAM_BASE;
    wire in_sram   = addr >= mem_attr_pkg::SRAM_BASE    && addr < mem_attr_pkg::PERIPH_BASE;
    wire in_periph = addr >= mem_attr_pkg::PERIPH_BASE  && addr < mem_attr_pkg::EXT_RAM_BASE;
    wire in_eram   = addr >= mem_attr_pkg::EXT_RAM_BASE && addr < mem_attr_pkg::EXT_DEV_BASE;
    wire in_edev   = addr >= mem_attr_pkg::EXT_DEV_BASE && addr < mem_attr_pkg::PPB_BASE;
    wire in_ppb    = addr >= mem_attr_pkg::PPB_BASE     && addr < mem_attr_pkg::RESERVED_BASE;
    wire is_normal = in_code | in_sram | in_eram;
    wire is_device = in_periph | in_edev;

    mem_attr_pkg::mem_type_t dflt_type;
    // Default type; anything above the private bus is reserved
    assign dflt_type = is_normal ? mem_attr_pkg::MT_NORMAL :
                       is_device ? mem_attr_pkg::MT_DEVICE :
                       in_ppb    ? mem_attr_pkg::MT_STRONG :
                                   mem_attr_pkg::MT_RESERVED;
    wire dflt_no_exec = !is_normal;

    // Protection unit settings override the default type and execute-never; the fault keeps the default map
    assign mtype         = prot_valid ? prot_type : dflt_type;
    assign execute_never = prot_valid ? prot_no_exec : dflt_no_exec;
    assign map_fault     = (dflt_type == mem_attr_pkg::MT_RESERVED);
endmodule
`default_nettype wire
